/* src/lls_link_status.sv */
/*
 * lls_link_status: per-lane receive status flags for lanes 5 to 7 of a
 * multi-lane serial link, an error threshold, control bits and an
 * interrupt, all reached over an APB slave.
 * Assumes per-lane error pulses, sync levels and configuration bytes
 * arrive synchronous to pclk from the lane receivers.
 */
// How it works
// [RULE1] disparity flag set when count reaches threshold
// [RULE2] invalid symbol flag set at threshold
// [RULE3] unexpected control flag set at threshold
// [RULE4] bit 4 shows lane deskew achieved
// [RULE5] bit 3 shows initial alignment sync
// [RULE6] bit 2 shows configuration checksum correct
// [RULE7] bit 1 shows frame sync achieved
// [RULE8] bit 0 shows code group sync
// [RULE9] software ignores bits 4..1 when skipping alignment
// [RULE10] three counters per lane against shared threshold
// [RULE11] status read only, reset zero, no side effects
`timescale 1ns/1ps
module lls_link_status
    import lls_pkg::*;
#(
    parameter int LANES = LLS_LANES
)
(
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // lane receivers
    input wire logic [LANES-1:0] disparity_err,
    input wire logic [LANES-1:0] invalid_symbol_err,
    input wire logic [LANES-1:0] unexpected_ctrl_char_err,
    input wire logic [LANES-1:0] lane_deskew_done,
    input wire logic [LANES-1:0] initial_align_sync_done,
    input wire logic [LANES-1:0] frame_sync_done,
    input wire logic [LANES-1:0] code_group_sync_done,
    input wire logic [LANES-1:0] cfg_valid,
    input wire logic [LANES-1:0] cfg_last,
    input wire logic [LANES-1:0][7:0] cfg_byte,
    // to the receivers and the interrupt controller
    output logic skip_initial_alignment,
    output logic irq
);

    // ************************************************
    // elaboration checks
    // ************************************************
    if (LANES < 1 || LANES > LLS_LANES) begin : g_lanes_check
        $error("lls_link_status: LANES must be 1 to 3");
    end

    // ************************************************
    // declarations
    // ************************************************
    lls_apb_state_t apb_state;
    lls_apb_state_t next_apb_state;
    logic [LLS_IDX_W-1:0] reg_idx;
    logic aligned;
    logic wr_commit;
    logic [LLS_CNT_W-1:0] error_count_threshold;
    logic clear_counts;
    logic [LANES-1:0][7:0] link_status;
    logic [LANES-1:0] disparity_err_flag;
    logic [LANES-1:0] invalid_symbol_err_flag;
    logic [LANES-1:0] unexpected_ctrl_char_flag;
    logic [LANES-1:0] config_checksum_ok;
    logic [LANES-1:0] prev_err_any;
    logic [LANES-1:0] prev_cgs;
    logic [2*LANES-1:0] irq_status;
    logic [2*LANES-1:0] irq_mask;
    logic [2*LANES-1:0] irq_event;
    logic [31:0] next_prdata;
    logic next_pslverr;

    // ************************************************
    // address decode
    // ************************************************
    // word index from the byte address
    assign reg_idx = paddr[13:2];
    assign aligned = (paddr[1:0] == 2'b00) && (paddr[15:14] == 2'b00);
    // a write lands only at the edge that samples pready high
    assign wr_commit = psel && penable && pready && pwrite && !pslverr;

    // ************************************************
    // per-lane counters, checksum and flags
    // ************************************************
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        lls_err_counter u_disp (
            .pclk(pclk),
            .presetn(presetn),
            .err_pulse(disparity_err[l]),
            .clear(clear_counts),
            .threshold(error_count_threshold),
            .at_threshold(disparity_err_flag[l])
        );
        lls_err_counter u_nit (
            .pclk(pclk),
            .presetn(presetn),
            .err_pulse(invalid_symbol_err[l]),
            .clear(clear_counts),
            .threshold(error_count_threshold),
            .at_threshold(invalid_symbol_err_flag[l])
        );
        lls_err_counter u_uek (
            .pclk(pclk),
            .presetn(presetn),
            .err_pulse(unexpected_ctrl_char_err[l]),
            .clear(clear_counts),
            .threshold(error_count_threshold),
            .at_threshold(unexpected_ctrl_char_flag[l])
        );
        lls_cfg_checksum u_cks (
            .pclk(pclk),
            .presetn(presetn),
            .cfg_valid(cfg_valid[l]),
            .cfg_last(cfg_last[l]),
            .cfg_byte(cfg_byte[l]),
            .checksum_ok(config_checksum_ok[l])
        );

        // status byte, rebuilt every cycle, read only
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                link_status[l] <= LLS_STATUS_RST; // [RULE11]
            end else begin
                link_status[l][LLS_BIT_DISPARITY] <= disparity_err_flag[l]; // [RULE1]
                link_status[l][LLS_BIT_INVALID_SYMBOL] <= invalid_symbol_err_flag[l]; // [RULE2]
                link_status[l][LLS_BIT_UNEXPECTED_CTRL] <= unexpected_ctrl_char_flag[l]; // [RULE3]
                link_status[l][LLS_BIT_DESKEW] <= lane_deskew_done[l]; // [RULE4]
                link_status[l][LLS_BIT_INITIAL_ALIGN] <= initial_align_sync_done[l]; // [RULE5]
                link_status[l][LLS_BIT_CHECKSUM] <= config_checksum_ok[l]; // [RULE6]
                link_status[l][LLS_BIT_FRAME_SYNC] <= frame_sync_done[l]; // [RULE7]
                link_status[l][LLS_BIT_CODE_GROUP_SYNC] <= code_group_sync_done[l]; // [RULE8]
            end
        end

        // edges of the registered flags feed the interrupt events
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                prev_err_any[l] <= 1'b0;
                prev_cgs[l] <= 1'b0;
            end else begin
                prev_err_any[l] <= |link_status[l][7:5];
                prev_cgs[l] <= link_status[l][LLS_BIT_CODE_GROUP_SYNC];
            end
        end

        // threshold reached, and code group sync lost
        assign irq_event[l] = (|link_status[l][7:5]) && !prev_err_any[l];
        assign irq_event[LANES+l] = prev_cgs[l] && !link_status[l][LLS_BIT_CODE_GROUP_SYNC];
    end

    // ************************************************
    // control registers
    // ************************************************
    // threshold shared by all counters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            error_count_threshold <= LLS_THRESHOLD_RST;
        end else if (wr_commit && reg_idx == LLS_IDX_THRESHOLD) begin
            error_count_threshold <= pwdata[LLS_CNT_W-1:0]; // [RULE10]
        end
    end

    // skip-alignment level and one-cycle counter clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            skip_initial_alignment <= 1'b0;
            clear_counts <= 1'b0;
        end else begin
            clear_counts <= wr_commit && reg_idx == LLS_IDX_CTRL
                && pwdata[LLS_CTRL_CLEAR_COUNTS];
            if (wr_commit && reg_idx == LLS_IDX_CTRL) begin
                skip_initial_alignment <= pwdata[LLS_CTRL_SKIP_ALIGN];
            end
        end
    end

    // ************************************************
    // interrupts
    // ************************************************
    // sticky status, write one to clear, a new event wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= '0;
        end else if (wr_commit && reg_idx == LLS_IDX_IRQ_STATUS) begin
            irq_status <= (irq_status & ~pwdata[2*LANES-1:0]) | irq_event;
        end else begin
            irq_status <= irq_status | irq_event;
        end
    end

    // mask, one enables the source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= '0;
        end else if (wr_commit && reg_idx == LLS_IDX_IRQ_MASK) begin
            irq_mask <= pwdata[2*LANES-1:0];
        end
    end

    // level output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

    // ************************************************
    // apb read mux and error decode
    // ************************************************
    // plain reads, nothing changes when a register is read
    always_comb begin
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        if (!aligned) begin
            next_pslverr = 1'b1;
        end else if (reg_idx >= LLS_IDX_LANE5_LINK_STATUS
                && reg_idx <= LLS_IDX_LANE7_LINK_STATUS) begin
            next_pslverr = 1'b1;
            for (int l = 0; l < LANES; l++) begin
                if (reg_idx == LLS_IDX_LANE5_LINK_STATUS + LLS_IDX_W'(l)) begin
                    next_prdata[7:0] = link_status[l]; // [RULE11]
                    next_pslverr = pwrite;
                end
            end
        end else begin
            unique case (reg_idx)
                LLS_IDX_THRESHOLD: next_prdata[LLS_CNT_W-1:0] = error_count_threshold;
                LLS_IDX_CTRL: next_prdata[LLS_CTRL_SKIP_ALIGN] = skip_initial_alignment;
                LLS_IDX_IRQ_STATUS: next_prdata[2*LANES-1:0] = irq_status;
                LLS_IDX_IRQ_MASK: next_prdata[2*LANES-1:0] = irq_mask;
                default: next_pslverr = 1'b1;
            endcase
        end
    end

    // ************************************************
    // apb handshake
    // ************************************************
    // one wait-free access: ready in the first access cycle
    always_comb begin
        next_apb_state = apb_state;
        unique case (apb_state)
            LLS_APB_IDLE: begin
                if (psel && !penable) begin
                    next_apb_state = LLS_APB_ACCESS;
                end
            end
            LLS_APB_ACCESS: begin
                next_apb_state = LLS_APB_IDLE;
            end
            default: next_apb_state = LLS_APB_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            apb_state <= LLS_APB_IDLE;
        end else begin
            apb_state <= next_apb_state;
        end
    end

    // answer captured at the setup edge, dropped after the access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (apb_state == LLS_APB_IDLE && psel && !penable) begin
            pready <= 1'b1;
            pslverr <= next_pslverr;
            prdata <= pwrite ? 32'h0000_0000 : next_prdata;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule

/* common/lls_pkg.sv */
/*
 * lls_pkg: register indices, field positions, reset values and
 * widths shared by the lane link status flag block.
 * Assumes an APB slave with 32-bit data; a register's byte address
 * is four times its index.
 */
package lls_pkg;

    // ************************************************
    // geometry
    // ************************************************
    localparam int LLS_LANES = 3;        // lanes 5 to 7
    localparam int LLS_FIRST_LANE = 5;
    localparam int LLS_CNT_W = 8;        // error counters and threshold
    localparam int LLS_IDX_W = 12;

    // ************************************************
    // register indices (byte address = 4 * index)
    // ************************************************
    localparam logic [LLS_IDX_W-1:0] LLS_IDX_LANE5_LINK_STATUS = 12'h4b5;
    localparam logic [LLS_IDX_W-1:0] LLS_IDX_LANE6_LINK_STATUS = 12'h4b6;
    localparam logic [LLS_IDX_W-1:0] LLS_IDX_LANE7_LINK_STATUS = 12'h4b7;
    localparam logic [LLS_IDX_W-1:0] LLS_IDX_THRESHOLD = 12'h4c0;
    localparam logic [LLS_IDX_W-1:0] LLS_IDX_CTRL = 12'h4c1;
    localparam logic [LLS_IDX_W-1:0] LLS_IDX_IRQ_STATUS = 12'h4c2;
    localparam logic [LLS_IDX_W-1:0] LLS_IDX_IRQ_MASK = 12'h4c3;

    // ************************************************
    // link status byte fields
    // ************************************************
    localparam int LLS_BIT_DISPARITY = 7;
    localparam int LLS_BIT_INVALID_SYMBOL = 6;
    localparam int LLS_BIT_UNEXPECTED_CTRL = 5;
    localparam int LLS_BIT_DESKEW = 4;
    localparam int LLS_BIT_INITIAL_ALIGN = 3;
    localparam int LLS_BIT_CHECKSUM = 2;
    localparam int LLS_BIT_FRAME_SYNC = 1;
    localparam int LLS_BIT_CODE_GROUP_SYNC = 0;

    // ************************************************
    // control register fields
    // ************************************************
    localparam int LLS_CTRL_SKIP_ALIGN = 0;
    localparam int LLS_CTRL_CLEAR_COUNTS = 1;  // self-clearing

    // ************************************************
    // reset values
    // ************************************************
    localparam logic [7:0] LLS_STATUS_RST = 8'h00;
    localparam logic [LLS_CNT_W-1:0] LLS_THRESHOLD_RST = 8'hff;
    localparam logic [LLS_CNT_W-1:0] LLS_COUNT_RST = 8'h00;
    localparam logic [LLS_CNT_W-1:0] LLS_COUNT_MAX = 8'hff;
    localparam logic [7:0] LLS_SUM_RST = 8'h00;

    // apb answer state
    typedef enum logic [1:0] {
        LLS_APB_IDLE = 2'b01,
        LLS_APB_ACCESS = 2'b10
    } lls_apb_state_t;

endpackage

/* src/lls_err_counter.sv */
/*
 * lls_err_counter: saturating error counter for one error type of one
 * lane, compared against the shared threshold.
 * Assumes err_pulse is one cycle per received error, synchronous to pclk.
 */
`timescale 1ns/1ps
module lls_err_counter
    import lls_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic err_pulse,
    input wire logic clear,
    input wire logic [LLS_CNT_W-1:0] threshold,
    output logic at_threshold
);

    logic [LLS_CNT_W-1:0] count;

    // count errors, hold at the top, clear on request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= LLS_COUNT_RST;
        end else if (clear) begin
            count <= LLS_COUNT_RST;
        end else if (err_pulse && count != LLS_COUNT_MAX) begin
            count <= count + 8'h01;
        end
    end

    // flag at or above threshold, low below it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            at_threshold <= 1'b0;
        end else begin
            at_threshold <= (count >= threshold); // [RULE10]
        end
    end

endmodule

/* src/lls_cfg_checksum.sv */
/*
 * lls_cfg_checksum: sums the received lane configuration bytes modulo
 * 256 and compares the sum with the checksum byte that closes them.
 * Assumes cfg_valid marks each byte and cfg_last marks the checksum byte.
 */
`timescale 1ns/1ps
module lls_cfg_checksum
    import lls_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cfg_valid,
    input wire logic cfg_last,
    input wire logic [7:0] cfg_byte,
    output logic checksum_ok
);

    logic [7:0] sum;

    // running sum over the configuration bytes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sum <= LLS_SUM_RST;
        end else if (cfg_valid) begin
            sum <= cfg_last ? LLS_SUM_RST : sum + cfg_byte;
        end
    end

    // verdict on the checksum byte, held until the next one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            checksum_ok <= 1'b0;
        end else if (cfg_valid && cfg_last) begin
            checksum_ok <= (sum == cfg_byte); // [RULE6]
        end
    end

endmodule

/* tb/lls_link_status_sva.sv */
/*
 * lls_link_status_sva: checks of the apb answer and the status bytes.
 * Assumes only the top module's ports; bound below.
 */
`timescale 1ns/1ps
module lls_link_status_sva
    import lls_pkg::*;
#(
    parameter int LANES = LLS_LANES
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic [LANES-1:0] lane_deskew_done,
    input wire logic [LANES-1:0] initial_align_sync_done,
    input wire logic [LANES-1:0] frame_sync_done,
    input wire logic [LANES-1:0] code_group_sync_done
);
    // ************************************************
    // helper logic
    // ************************************************
    logic [3:0] lv;
    logic [3:0] lv_q;
    logic [2:0] stab;
    logic st_hit;
    logic [15:0] a_st5;

    assign a_st5 = {2'b00, LLS_IDX_LANE5_LINK_STATUS, 2'b00};
    assign lv = {lane_deskew_done[0], initial_align_sync_done[0], frame_sync_done[0],
                 code_group_sync_done[0]};
    assign st_hit = paddr[15:14] == 2'b00 && paddr[1:0] == 2'b00 &&
                    paddr[13:2] >= LLS_IDX_LANE5_LINK_STATUS &&
                    paddr[13:2] <= LLS_IDX_LANE7_LINK_STATUS;

    // counts edges since lane 5 levels last changed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lv_q <= 4'h0;
            stab <= 3'h0;
        end else begin
            lv_q <= lv;
            stab <= (lv != lv_q) ? 3'h0 : ((stab == 3'h7) ? stab : stab + 3'h1);
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ************************************************
    // assertions
    // ************************************************
    chk_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    chk_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no answer in the cycle after setup");
    chk_ready_has_cause: assert property (pready |-> $past(psel) && !$past(penable))
        else $error("pready without a setup cycle");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr outside an answer");
    chk_unaligned_refused: assert property (
        psel && !penable && paddr[1:0] != 2'b00 |=> pslverr)
        else $error("unaligned access accepted");
    chk_status_read_only: assert property (
        psel && !penable && pwrite && st_hit |=> pready && pslverr)
        else $error("write to a status byte accepted");
    chk_status_upper_zero: assert property (
        pready && !pwrite && !pslverr && st_hit |-> prdata[31:8] == 24'h0)
        else $error("status read has upper bits set");
    chk_lane5_levels: assert property (
        pready && !pwrite && paddr == a_st5 && stab >= 3'h5
        |-> {prdata[4], prdata[3], prdata[1], prdata[0]} == lv)
        else $error("lane 5 sync bits differ from inputs");

    // ************************************************
    // covers
    // ************************************************
    cov_level_read: cover property (pready && !pwrite && paddr == a_st5 && stab >= 3'h5);
    cov_refused: cover property (pslverr);
    cov_irq_rise: cover property ($rose(irq));
endmodule

bind lls_link_status lls_link_status_sva #(.LANES(LANES)) u_sva (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .irq(irq),
    .lane_deskew_done(lane_deskew_done),
    .initial_align_sync_done(initial_align_sync_done),
    .frame_sync_done(frame_sync_done),
    .code_group_sync_done(code_group_sync_done)
);

/* tb/lls_lane_tx_model.sv */
/*
 * lls_lane_tx_model: far end of the lanes: error pulses, sync levels
 * and configuration bytes. Assumes the bench calls its tasks.
 */
`timescale 1ns/1ps
module lls_lane_tx_model #(
    parameter int LANES = 3
)
(
    input wire logic pclk,
    output logic [LANES-1:0] disparity_err,
    output logic [LANES-1:0] invalid_symbol_err,
    output logic [LANES-1:0] unexpected_ctrl_char_err,
    output logic [LANES-1:0] lane_deskew_done,
    output logic [LANES-1:0] initial_align_sync_done,
    output logic [LANES-1:0] frame_sync_done,
    output logic [LANES-1:0] code_group_sync_done,
    output logic [LANES-1:0] cfg_valid,
    output logic [LANES-1:0] cfg_last,
    output logic [LANES-1:0][7:0] cfg_byte
);
    logic [2:0][LANES-1:0] err;

    // error kinds 0..2 map to disparity, invalid symbol, unexpected control
    assign disparity_err = err[0];
    assign invalid_symbol_err = err[1];
    assign unexpected_ctrl_char_err = err[2];

    initial begin
        err = '0;
        {lane_deskew_done, initial_align_sync_done, frame_sync_done, code_group_sync_done} = '0;
        {cfg_valid, cfg_last, cfg_byte} = '0;
    end

    // one-cycle error pulses, gap+1 idle cycles apart (0 = every other cycle)
    task automatic send_err(input int l, input int k, input int n, input int gap);
        repeat (n) begin
            @(posedge pclk);
            err[k][l] <= 1'b1;
            @(posedge pclk);
            err[k][l] <= 1'b0;
            repeat (gap) @(posedge pclk);
        end
    endtask

    // sync levels: deskew, initial alignment, frame, code group
    task automatic set_lvl(input int l, input logic [3:0] v);
        @(posedge pclk);
        {lane_deskew_done[l], initial_align_sync_done[l], frame_sync_done[l],
         code_group_sync_done[l]} <= v;
    endtask

    // three bytes then the checksum byte, right or off by one
    task automatic send_cfg(input int l, input logic good);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 1; i <= 3; i++) begin
            @(posedge pclk);
            cfg_valid[l] <= 1'b1;
            cfg_byte[l] <= 8'(i * 8'h11);
            s = s + 8'(i * 8'h11);
        end
        @(posedge pclk);
        cfg_last[l] <= 1'b1;
        cfg_byte[l] <= good ? s : (s ^ 8'h01);
        @(posedge pclk);
        cfg_valid[l] <= 1'b0;
        cfg_last[l] <= 1'b0;
        cfg_byte[l] <= ~cfg_byte[l]; // released byte lane shows junk
    endtask
endmodule

/* tb/lane_link_status_flags_tb.sv */
/*
 * lane_link_status_flags_tb: apb tests of the status, threshold, control
 * and interrupt registers. Assumes the lane transmitter model.
 */
`timescale 1ns/1ps
module lane_link_status_flags_tb
    import lls_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, skip, irq, err;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] de, ia, fs, cg, dp, iv, uc, cv, cl;
    logic [2:0][7:0] cb;
    logic [3:0] lvl [3] = '{default: '0};
    logic [2:0] flg [3] = '{default: '0};
    logic cks [3] = '{default: '0};
    logic [3:0] pat [3] = '{4'b1011, 4'b0110, 4'b1101};
    int error_cnt = 0;
    int samples_checked = 0;
    localparam logic [15:0] A_ST = {2'b00, LLS_IDX_LANE5_LINK_STATUS, 2'b00};
    localparam logic [15:0] A_THR = {2'b00, LLS_IDX_THRESHOLD, 2'b00};
    localparam logic [15:0] A_CTRL = {2'b00, LLS_IDX_CTRL, 2'b00};
    localparam logic [15:0] A_IST = {2'b00, LLS_IDX_IRQ_STATUS, 2'b00};
    localparam logic [15:0] A_IMSK = {2'b00, LLS_IDX_IRQ_MASK, 2'b00};

    lls_link_status #(.LANES(3)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .disparity_err(dp),
        .invalid_symbol_err(iv), .unexpected_ctrl_char_err(uc), .lane_deskew_done(de),
        .initial_align_sync_done(ia), .frame_sync_done(fs), .code_group_sync_done(cg),
        .cfg_valid(cv), .cfg_last(cl), .cfg_byte(cb), .skip_initial_alignment(skip),
        .irq(irq));

    lls_lane_tx_model #(.LANES(3)) u_tx (.pclk(pclk), .disparity_err(dp),
        .invalid_symbol_err(iv), .unexpected_ctrl_char_err(uc), .lane_deskew_done(de),
        .initial_align_sync_done(ia), .frame_sync_done(fs), .code_group_sync_done(cg),
        .cfg_valid(cv), .cfg_last(cl), .cfg_byte(cb));

    // ************************************************
    // clock, tasks
    // ************************************************
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic give_verdict();
        $display("checked %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp, input logic [7:0] m);
        apb(1'b0, a, 32'h0);
        chk(rd & {24'hffffff, m}, exp & {24'hffffff, m});
    endtask

    function automatic logic [31:0] stat(input int l);
        return {24'h0, flg[l], lvl[l][3], lvl[l][2], cks[l], lvl[l][1:0]};
    endfunction

    task automatic rd_all(input logic [7:0] m);
        for (int l = 0; l < 3; l++) rd_chk(A_ST + 16'(4 * l), stat(l), m);
    endtask

    // ************************************************
    // tests
    // ************************************************
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd_all(8'hff);
        rd_chk(A_THR, 32'hff, 8'hff);
        rd_chk(A_CTRL, 32'h0, 8'hff);
        rd_chk(A_IMSK, 32'h0, 8'hff);
        // refused accesses
        apb(1'b1, A_ST + 16'h4, 32'hff);
        chk(32'(err), 32'h1);
        rd_chk(A_ST + 16'h4, 32'h0, 8'hff);
        apb(1'b0, A_IMSK + 16'h4, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b0, A_ST + 16'h1, 32'h0);
        chk(32'(err), 32'h1);
        // sync levels per lane
        for (int l = 0; l < 3; l++) begin
            u_tx.set_lvl(l, pat[l]);
            lvl[l] = pat[l];
        end
        repeat (6) @(posedge pclk);
        rd_all(8'hff);
        // checksum good on lane 5, bad on lane 6
        u_tx.send_cfg(0, 1'b1);
        u_tx.send_cfg(1, 1'b0);
        cks[0] = 1'b1;
        repeat (3) @(posedge pclk);
        rd_all(8'hff);
        // threshold 3, one error kind per lane
        apb(1'b1, A_THR, 32'h3);
        for (int k = 0; k < 3; k++) begin
            u_tx.send_err(k, k, 2, k);
            repeat (4) @(posedge pclk);
            rd_chk(A_ST + 16'(4 * k), stat(k), 8'hff);
            u_tx.send_err(k, k, 1, 0);
            repeat (4) @(posedge pclk);
            flg[k][2-k] = 1'b1;
            rd_chk(A_ST + 16'(4 * k), stat(k), 8'hff);
        end
        apb(1'b1, A_THR, 32'h4);
        repeat (4) @(posedge pclk);
        flg = '{default: '0};
        rd_all(8'hff);
        // interrupt: raise, mask, clear, sync loss
        rd_chk(A_IST, 32'h7, 8'hff);
        chk(32'(irq), 32'h0);
        apb(1'b1, A_IMSK, 32'h3f);
        repeat (3) @(posedge pclk);
        chk(32'(irq), 32'h1);
        apb(1'b1, A_IST, 32'h7);
        repeat (3) @(posedge pclk);
        chk(32'(irq), 32'h0);
        rd_chk(A_IST, 32'h0, 8'hff);
        u_tx.set_lvl(0, 4'b1010);
        lvl[0] = 4'b1010;
        repeat (3) @(posedge pclk);
        rd_chk(A_IST, 32'h8, 8'hff);
        // clear counts with skip set; bits 4..1 ignored
        apb(1'b1, A_THR, 32'h3);
        apb(1'b1, A_CTRL, 32'h3);
        repeat (4) @(posedge pclk);
        rd_chk(A_CTRL, 32'h1, 8'hff);
        chk(32'(skip), 32'h1);
        rd_all(8'he1);
        give_verdict();
    end

    // watchdog
    initial begin
        repeat (5000) @(posedge pclk);
        error_cnt++;
        give_verdict();
    end
endmodule
